/* dcf_fifo.sv */
// Deep 18-bit FIFO with level flags, threshold registers and AXI4-Lite status.
// Assumes one clock; write and read edges arrive as one-cycle tick inputs.
`timescale 1ns/100ps
`include "dcf_defs.svh"
module dcf_fifo #(
    parameter int ADDR_W = 15,
    parameter int DATA_W = 18
) (
    input  wire logic              ref_clk_in,
    input  wire logic              srst_in,
    input  wire logic              wr_tick_in,
    input  wire logic              rd_tick_in,
    input  wire logic              cold_init_n_in,
    input  wire logic              warm_init_n_in,
    input  wire logic              replay_req_n_in,
    input  wire logic              lookahead_sel_bit_in,
    input  wire logic              bit_load_en_n_in,
    input  wire logic              thresh_access_n_in,
    input  wire logic              push_en_n_in,
    input  wire logic              pop_en_n_in,
    input  wire logic              out_en_n_in,
    input  wire logic [DATA_W-1:0] write_data_in,
    output logic      [DATA_W-1:0] read_data_out,
    output logic                   read_data_oe_n_out,
    output logic                   full_space_pin_out,
    output logic                   empty_valid_pin_out,
    output logic                   near_full_n_out,
    output logic                   near_empty_n_out,
    output logic                   half_level_n_out,
    input  wire logic [7:0]        s_axi_awaddr_in,
    input  wire logic              s_axi_awvalid_in,
    output logic                   s_axi_awready_out,
    input  wire logic [31:0]       s_axi_wdata_in,
    input  wire logic [3:0]        s_axi_wstrb_in,
    input  wire logic              s_axi_wvalid_in,
    output logic                   s_axi_wready_out,
    output logic [1:0]             s_axi_bresp_out,
    output logic                   s_axi_bvalid_out,
    input  wire logic              s_axi_bready_in,
    input  wire logic [7:0]        s_axi_araddr_in,
    input  wire logic              s_axi_arvalid_in,
    output logic                   s_axi_arready_out,
    output logic [31:0]            s_axi_rdata_out,
    output logic [1:0]             s_axi_rresp_out,
    output logic                   s_axi_rvalid_out,
    input  wire logic              s_axi_rready_in
);
    localparam int PW = ADDR_W + 1;
    localparam logic [PW-1:0] FULL_CNT = {1'b1, {ADDR_W{1'b0}}};
    localparam logic [PW-1:0] HALF_CNT = {2'b01, {(ADDR_W-1){1'b0}}};
    localparam logic [ADDR_W-1:0] THR_LO = ADDR_W'(`DCF_THR_LO);
    localparam logic [ADDR_W-1:0] THR_HI = ADDR_W'(`DCF_THR_HI);

    dcf_pkg::dcf_cfg_t      cfg_r;
    logic [DATA_W-1:0]      mem [0:(1<<ADDR_W)-1];
    logic [2*ADDR_W-1:0]    thr_r;
    logic                   wsel_r;
    logic                   rsel_r;
    logic [PW-1:0]          wptr_r;
    logic [PW-1:0]          wgray_r;
    logic [PW-1:0]          rptr_r;
    logic [PW-1:0]          rgray_r;
    logic [PW-1:0]          w_rg1_r;
    logic [PW-1:0]          w_rg2_r;
    logic [PW-1:0]          r_wg1_r;
    logic [PW-1:0]          r_wg2_r;
    logic [DATA_W-1:0]      read_data_r;
    logic                   valid_r;
    logic [1:0]             hold_r;
    logic                   oe_n_r;
    logic                   full_space_r;
    logic                   empty_valid_r;
    logic                   near_full_n_r;
    logic                   near_empty_n_r;
    logic                   half_n_r;
    logic                   warm_pulse_r;
    logic                   aw_rdy_r;
    logic                   w_rdy_r;
    logic [7:0]             awaddr_r;
    logic [31:0]            wdata_r;
    logic [3:0]             wstrb_r;
    logic                   bvalid_r;
    logic [1:0]             bresp_r;
    logic                   ar_rdy_r;
    logic                   rvalid_r;
    logic [31:0]            rdata_r;
    logic [1:0]             rresp_r;
    logic [31:0]            rd_mux;
    logic                   rd_hit;

    function automatic logic [PW-1:0] g2b(input logic [PW-1:0] g);
        logic [PW-1:0] b;
        b = g;
        for (int i = PW - 2; i >= 0; i--)
        begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    function automatic logic [PW-1:0] b2g(input logic [PW-1:0] b);
        return (b >> 1) ^ b;
    endfunction

    function automatic logic addr_ok(input logic [7:0] a);
        return a == `DCF_OFS_CTRL || a == `DCF_OFS_STAT ||
               a == `DCF_OFS_THE || a == `DCF_OFS_THF;
    endfunction

    // Init terms
    wire init_all = srst_in | ~cold_init_n_in;
    wire init_ptr = init_all | ~warm_init_n_in | warm_pulse_r;

    // Side counts from synchronised gray copies
    wire [PW-1:0] wcnt     = wptr_r - g2b(w_rg2_r);
    wire [PW-1:0] rcnt     = g2b(r_wg2_r) - rptr_r;
    wire          full_w   = wcnt[ADDR_W];
    wire          empty_w  = rcnt == {PW{1'b0}};
    wire          acc_w    = ~thresh_access_n_in;
    wire          push_w   = wr_tick_in & ~push_en_n_in & ~acc_w & ~full_w;
    wire          pop_w    = rd_tick_in & ~pop_en_n_in;
    wire          replay_w = rd_tick_in & ~replay_req_n_in;
    wire          blocked  = empty_w | (hold_r != 2'h0);
    wire [ADDR_W-1:0] thr_e = thr_r[ADDR_W-1:0];
    wire [ADDR_W-1:0] thr_f = thr_r[2*ADDR_W-1:ADDR_W];

    // Configuration latch
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
            cfg_r <= '0;
        else if (~cold_init_n_in)
        begin
            cfg_r.lookahead <= lookahead_sel_bit_in;
            cfg_r.thr_hi    <= thresh_access_n_in;
            cfg_r.serial    <= thresh_access_n_in;
        end
    end

    // Threshold registers
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            thr_r  <= {THR_LO, THR_LO};
            wsel_r <= 1'b0;
        end
        else if (~cold_init_n_in)
        begin
            thr_r  <= thresh_access_n_in ? {THR_HI, THR_HI} : {THR_LO, THR_LO};
            wsel_r <= 1'b0;
        end
        else if (wr_tick_in && acc_w)
        begin
            if (cfg_r.serial && ~bit_load_en_n_in)
                thr_r <= {lookahead_sel_bit_in, thr_r[2*ADDR_W-1:1]};
            else if (~cfg_r.serial && ~push_en_n_in)
            begin
                if (wsel_r)
                    thr_r[2*ADDR_W-1:ADDR_W] <= write_data_in[ADDR_W-1:0];
                else
                    thr_r[ADDR_W-1:0] <= write_data_in[ADDR_W-1:0];
                wsel_r <= ~wsel_r;
            end
        end
    end

    // Storage array
    always_ff @(posedge ref_clk_in)
    begin
        if (push_w && !init_ptr)
            mem[wptr_r[ADDR_W-1:0]] <= write_data_in;
    end

    // Write pointer
    always_ff @(posedge ref_clk_in)
    begin
        if (init_ptr)
        begin
            wptr_r  <= '0;
            wgray_r <= '0;
        end
        else if (push_w)
        begin
            wptr_r  <= wptr_r + PW'(1);
            wgray_r <= b2g(wptr_r + PW'(1));
        end
    end

    // Pointer synchronisers
    always_ff @(posedge ref_clk_in)
    begin
        if (init_ptr)
        begin
            w_rg1_r <= '0;
            w_rg2_r <= '0;
            r_wg1_r <= '0;
            r_wg2_r <= '0;
        end
        else
        begin
            w_rg1_r <= rgray_r;
            w_rg2_r <= w_rg1_r;
            r_wg1_r <= wgray_r;
            r_wg2_r <= r_wg1_r;
        end
    end

    // Read pointer and output register
    always_ff @(posedge ref_clk_in)
    begin
        if (init_ptr)
        begin
            rptr_r      <= '0;
            rgray_r     <= '0;
            read_data_r <= '0;
            valid_r     <= 1'b0;
            rsel_r      <= 1'b0;
            hold_r      <= 2'h0;
        end
        else if (replay_w)
        begin
            rptr_r  <= '0;
            rgray_r <= '0;
            valid_r <= 1'b0;
            hold_r  <= `DCF_REPLAY_HOLD;
        end
        else if (rd_tick_in)
        begin
            if (hold_r != 2'h0)
                hold_r <= hold_r - 2'h1;
            if (acc_w && ~pop_en_n_in)
            begin
                read_data_r <= rsel_r ? DATA_W'(thr_f) : DATA_W'(thr_e);
                rsel_r      <= ~rsel_r;
            end
            else if (cfg_r.lookahead)
            begin
                if ((!valid_r || ~pop_en_n_in) && !blocked)
                begin
                    read_data_r <= mem[rptr_r[ADDR_W-1:0]];
                    valid_r     <= 1'b1;
                    rptr_r      <= rptr_r + PW'(1);
                    rgray_r     <= b2g(rptr_r + PW'(1));
                end
                else if (~pop_en_n_in)
                    valid_r <= 1'b0;
            end
            else if (~pop_en_n_in && !blocked)
            begin
                read_data_r <= mem[rptr_r[ADDR_W-1:0]];
                rptr_r      <= rptr_r + PW'(1);
                rgray_r     <= b2g(rptr_r + PW'(1));
            end
        end
    end

    // Write-side flags
    always_ff @(posedge ref_clk_in)
    begin
        if (init_all)
        begin
            full_space_r  <= ~cold_init_n_in & ~lookahead_sel_bit_in;
            near_full_n_r <= 1'b1;
            half_n_r      <= 1'b1;
        end
        else
        begin
            full_space_r  <= cfg_r.lookahead ? full_w : ~full_w;
            near_full_n_r <= ~(wcnt > (FULL_CNT - {1'b0, thr_f}));
            half_n_r      <= ~(wcnt > HALF_CNT);
        end
    end

    // Read-side flags and output enable
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            empty_valid_r  <= 1'b0;
            near_empty_n_r <= 1'b0;
            oe_n_r         <= 1'b1;
        end
        else
        begin
            empty_valid_r  <= cfg_r.lookahead ? ~valid_r : ~blocked;
            near_empty_n_r <= ~(rcnt < {1'b0, thr_e});
            oe_n_r         <= out_en_n_in;
        end
    end

    // AXI4-Lite write channel
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            aw_rdy_r     <= 1'b1;
            w_rdy_r      <= 1'b1;
            bvalid_r     <= 1'b0;
            bresp_r      <= `DCF_RESP_OK;
            awaddr_r     <= '0;
            wdata_r      <= '0;
            wstrb_r      <= '0;
            warm_pulse_r <= 1'b0;
        end
        else
        begin
            warm_pulse_r <= 1'b0;
            if (s_axi_awvalid_in && aw_rdy_r)
            begin
                aw_rdy_r <= 1'b0;
                awaddr_r <= s_axi_awaddr_in;
            end
            if (s_axi_wvalid_in && w_rdy_r)
            begin
                w_rdy_r <= 1'b0;
                wdata_r <= s_axi_wdata_in;
                wstrb_r <= s_axi_wstrb_in;
            end
            if (!aw_rdy_r && !w_rdy_r && !bvalid_r)
            begin
                bvalid_r <= 1'b1;
                bresp_r  <= addr_ok(awaddr_r) ? `DCF_RESP_OK : `DCF_RESP_ERR;
                if (awaddr_r == `DCF_OFS_CTRL && wstrb_r[0])
                    warm_pulse_r <= wdata_r[`DCF_CTRL_WARM];
            end
            if (bvalid_r && s_axi_bready_in)
            begin
                bvalid_r <= 1'b0;
                aw_rdy_r <= 1'b1;
                w_rdy_r  <= 1'b1;
            end
        end
    end

    // Register read mux
    always_comb
    begin
        rd_mux = '0;
        rd_hit = 1'b1;
        case (s_axi_araddr_in)
            `DCF_OFS_STAT:
            begin
                rd_mux[`DCF_STAT_EMPTY]       = empty_w;
                rd_mux[`DCF_STAT_FULL]        = full_w;
                rd_mux[`DCF_STAT_LOOK]        = cfg_r.lookahead;
                rd_mux[`DCF_STAT_SERIAL]      = cfg_r.serial;
                rd_mux[`DCF_STAT_CNT +: PW]   = wcnt;
            end
            `DCF_OFS_THE:  rd_mux[ADDR_W-1:0] = thr_e;
            `DCF_OFS_THF:  rd_mux[ADDR_W-1:0] = thr_f;
            `DCF_OFS_CTRL: rd_mux = '0;
            default:       rd_hit = 1'b0;
        endcase
    end

    // AXI4-Lite read channel
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            ar_rdy_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r  <= '0;
            rresp_r  <= `DCF_RESP_OK;
        end
        else if (s_axi_arvalid_in && ar_rdy_r)
        begin
            ar_rdy_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r  <= rd_mux;
            rresp_r  <= rd_hit ? `DCF_RESP_OK : `DCF_RESP_ERR;
        end
        else if (rvalid_r && s_axi_rready_in)
        begin
            rvalid_r <= 1'b0;
            ar_rdy_r <= 1'b1;
        end
    end

    assign read_data_out       = read_data_r;
    assign read_data_oe_n_out  = oe_n_r;
    assign full_space_pin_out  = full_space_r;
    assign empty_valid_pin_out = empty_valid_r;
    assign near_full_n_out     = near_full_n_r;
    assign near_empty_n_out    = near_empty_n_r;
    assign half_level_n_out    = half_n_r;
    assign s_axi_awready_out   = aw_rdy_r;
    assign s_axi_wready_out    = w_rdy_r;
    assign s_axi_bvalid_out    = bvalid_r;
    assign s_axi_bresp_out     = bresp_r;
    assign s_axi_arready_out   = ar_rdy_r;
    assign s_axi_rvalid_out    = rvalid_r;
    assign s_axi_rdata_out     = rdata_r;
    assign s_axi_rresp_out     = rresp_r;

    // Checks
    a_cold_clears_path: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        !cold_init_n_in |=> wptr_r == '0 && rptr_r == '0 && read_data_r == '0)
        else $error("cold init left pointers or data");
    a_cold_mode_latch: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        !cold_init_n_in |=> cfg_r.lookahead == $past(lookahead_sel_bit_in)
            && cfg_r.serial == $past(thresh_access_n_in))
        else $error("mode not latched");
    a_warm_keeps_cfg: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        cold_init_n_in && !warm_init_n_in |=> cfg_r == $past(cfg_r)
            && thr_r == $past(thr_r) && rptr_r == '0)
        else $error("warm init disturbed settings");
    a_replay_rewind: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        replay_w && !init_ptr |=> rptr_r == '0 && hold_r == `DCF_REPLAY_HOLD)
        else $error("replay did not rewind");
    a_replay_shows_empty: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        replay_w && !init_ptr && cold_init_n_in |=> ##1 empty_valid_pin_out == cfg_r.lookahead)
        else $error("replay flag wrong");
    a_serial_one_bit: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        cold_init_n_in && wr_tick_in && acc_w && cfg_r.serial && !bit_load_en_n_in
            |=> thr_r[2*ADDR_W-1] == $past(lookahead_sel_bit_in)
            && thr_r[2*ADDR_W-2:0] == $past(thr_r[2*ADDR_W-1:1]))
        else $error("serial shift wrong");
    a_full_push_ignored: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        !init_ptr && full_w |=> wptr_r == $past(wptr_r))
        else $error("push while full moved pointer");
    a_normal_no_fall: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        !init_ptr && !replay_w && !cfg_r.lookahead && !pop_w |=> $stable(read_data_r))
        else $error("data moved without pop");
    a_near_full_level: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        !init_all && wcnt > (FULL_CNT - {1'b0, thr_f}) |=> !near_full_n_out)
        else $error("near-full not low");
    a_oe_follows: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        out_en_n_in ##1 out_en_n_in |-> read_data_oe_n_out)
        else $error("data driven while disabled");
endmodule

/* dcf_defs.svh */
// Constants for the 18-bit level-flag FIFO: offsets, defaults, codes.
// Assumes inclusion by bare name from the design files.
`ifndef DCF_DEFS_SVH
`define DCF_DEFS_SVH
`define DCF_THR_LO       16'h007F
`define DCF_THR_HI       16'h03FF
`define DCF_OFS_CTRL     8'h00
`define DCF_OFS_STAT     8'h04
`define DCF_OFS_THE      8'h08
`define DCF_OFS_THF      8'h0C
`define DCF_RESP_OK      2'h0
`define DCF_RESP_ERR     2'h2
`define DCF_CTRL_WARM    0
`define DCF_STAT_EMPTY   0
`define DCF_STAT_FULL    1
`define DCF_STAT_LOOK    2
`define DCF_STAT_SERIAL  3
`define DCF_STAT_CNT     8
`define DCF_REPLAY_HOLD  2'h2
`endif

/* dcf_pkg.sv */
// Types for the 18-bit level-flag FIFO.
// Assumes nothing of its surroundings.
package dcf_pkg;
    typedef struct packed {
        logic lookahead;
        logic thr_hi;
        logic serial;
    } dcf_cfg_t;
endpackage

/* dcf_partner.sv */
// Writer and reader model driving the tick-marked ports of the FIFO.
// Assumes one caller at a time, entering just after a clock edge.
`timescale 1ns/100ps
module dcf_partner (
    input  wire logic   clk_in,
    output logic        wr_tick_out,
    output logic        rd_tick_out,
    output logic        push_n_out,
    output logic        pop_n_out,
    output logic        load_n_out,
    output logic        sel_bit_out,
    output logic        replay_n_out,
    output logic [17:0] data_out
);
    // Idle levels; the tie pin is outside the model and is driven by the bench
    initial
    begin
        {wr_tick_out, rd_tick_out, sel_bit_out} = 3'h0;
        {push_n_out, pop_n_out, load_n_out, replay_n_out} = 4'hF;
        data_out = 18'h0;
    end
    // Mode level for cold init
    task automatic sel(input logic b);
        sel_bit_out <= b;
    endtask
    // One write edge: push a word or shift one serial bit
    task automatic wr(input logic [17:0] d, input logic push, input logic b);
        @(posedge clk_in);
        wr_tick_out <= 1'h1;
        push_n_out <= ~push;
        load_n_out <= push;
        sel_bit_out <= b;
        data_out <= d;
        @(posedge clk_in);
        wr_tick_out <= 1'h0;
        {push_n_out, load_n_out} <= 2'h3;
        data_out <= ~d;
    endtask
    // One read edge with optional pop or replay
    task automatic rd(input logic pop, input logic rt);
        @(posedge clk_in);
        rd_tick_out <= 1'h1;
        pop_n_out <= ~pop;
        replay_n_out <= ~rt;
        @(posedge clk_in);
        rd_tick_out <= 1'h0;
        {pop_n_out, replay_n_out} <= 2'h3;
    endtask
endmodule

/* dual_clock_fifo_with_level_flags_tb_top.sv */
// Self-checking bench for the 18-bit level-flag FIFO at depth 16.
// Assumes dcf_partner drives the write and read ports.
`timescale 1ns/100ps
`include "dcf_defs.svh"
module dual_clock_fifo_with_level_flags_tb_top;
    localparam int AW = 4;
    logic        ref_clk_in = 1'h0, srst_in = 1'h1, cold_init_n_in = 1'h1, warm_init_n_in = 1'h1;
    logic        thresh_access_n_in = 1'h1, out_en_n_in = 1'h0;
    logic        wr_tick_in, rd_tick_in, replay_req_n_in, lookahead_sel_bit_in, bit_load_en_n_in;
    logic        push_en_n_in, pop_en_n_in, read_data_oe_n_out, full_space_pin_out, empty_valid_pin_out;
    logic        near_full_n_out, near_empty_n_out, half_level_n_out;
    logic [17:0] write_data_in, read_data_out;
    logic [7:0]  s_axi_awaddr_in = 8'h0, s_axi_araddr_in = 8'h0;
    logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out, lf = 32'h9d22, st;
    logic [3:0]  s_axi_wstrb_in = 4'hF;
    logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, rs;
    logic        s_axi_awvalid_in = 1'h0, s_axi_wvalid_in = 1'h0, s_axi_bready_in = 1'h0;
    logic        s_axi_arvalid_in = 1'h0, s_axi_rready_in = 1'h0;
    logic        s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
    logic [17:0] q[$];
    int          n_errors = 0, checks_done = 0;

    always #2.5 ref_clk_in = ~ref_clk_in;

    dcf_fifo #(.ADDR_W(AW)) dut (
        .ref_clk_in, .srst_in, .wr_tick_in, .rd_tick_in, .cold_init_n_in, .warm_init_n_in,
        .replay_req_n_in, .lookahead_sel_bit_in, .bit_load_en_n_in, .thresh_access_n_in,
        .push_en_n_in, .pop_en_n_in, .out_en_n_in, .write_data_in, .read_data_out, .read_data_oe_n_out,
        .full_space_pin_out, .empty_valid_pin_out, .near_full_n_out, .near_empty_n_out, .half_level_n_out,
        .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in,
        .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
        .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out,
        .s_axi_rvalid_out, .s_axi_rready_in);

    dcf_partner u_p (.clk_in(ref_clk_in), .wr_tick_out(wr_tick_in), .rd_tick_out(rd_tick_in),
        .push_n_out(push_en_n_in), .pop_n_out(pop_en_n_in), .load_n_out(bit_load_en_n_in),
        .sel_bit_out(lookahead_sel_bit_in), .replay_n_out(replay_req_n_in), .data_out(write_data_in));

    function automatic logic [31:0] nxt(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic test_done;
        if (n_errors == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= d;
        {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= 3'h7;
        do
        begin
            @(posedge ref_clk_in);
            if (s_axi_awready_out) s_axi_awvalid_in <= 1'h0;
            if (s_axi_wready_out) s_axi_wvalid_in <= 1'h0;
        end while (s_axi_bvalid_out !== 1'h1);
        rs = s_axi_bresp_out;
        s_axi_bready_in <= 1'h0;
        @(posedge ref_clk_in);
    endtask

    task automatic axi_rd(input logic [7:0] a);
        s_axi_araddr_in <= a;
        {s_axi_arvalid_in, s_axi_rready_in} <= 2'h3;
        do
        begin
            @(posedge ref_clk_in);
            if (s_axi_arready_out) s_axi_arvalid_in <= 1'h0;
        end while (s_axi_rvalid_out !== 1'h1);
        st = s_axi_rdata_out;
        rs = s_axi_rresp_out;
        s_axi_rready_in <= 1'h0;
        @(posedge ref_clk_in);
    endtask

    task automatic cold(input logic la, input logic acc);
        u_p.sel(la);
        cold_init_n_in <= 1'h0;
        thresh_access_n_in <= acc;
        repeat (2) @(posedge ref_clk_in);
        cold_init_n_in <= 1'h1;
        thresh_access_n_in <= 1'h1;
        repeat (3) @(posedge ref_clk_in);
    endtask

    task automatic pop_chk(input logic [17:0] e);
        u_p.rd(1'h1, 1'h0);
        @(posedge ref_clk_in);
        chk("read_data", 32'(read_data_out), 32'(e));
    endtask

    initial
    begin
        repeat (20000) @(posedge ref_clk_in);
        n_errors++;
        test_done();
    end

    initial
    begin
        repeat (3) @(posedge ref_clk_in);
        srst_in <= 1'h0;
        @(posedge ref_clk_in);
        cold(1'h0, 1'h1);
        axi_rd(`DCF_OFS_STAT);
        chk("serial", 32'(st[3]), 32'h1);
        chk("look_off", 32'(st[2]), 32'h0);
        lf = nxt(lf);
        thresh_access_n_in <= 1'h0;
        for (int i = 0; i < 2 * AW; i++)
            u_p.wr(18'h0, 1'h0, lf[i]);
        thresh_access_n_in <= 1'h1;
        axi_rd(`DCF_OFS_THE);
        chk("ser_n", 32'(st[AW-1:0]), 32'(lf[AW-1:0]));
        axi_rd(`DCF_OFS_THF);
        chk("ser_m", 32'(st[AW-1:0]), 32'(lf[2*AW-1:AW]));
        cold(1'h0, 1'h0);
        axi_rd(`DCF_OFS_STAT);
        chk("parallel", 32'(st[3]), 32'h0);
        thresh_access_n_in <= 1'h0;
        u_p.wr(18'h5, 1'h1, 1'h0);
        u_p.wr(18'h9, 1'h1, 1'h0);
        pop_chk(18'h5);
        thresh_access_n_in <= 1'h1;
        axi_rd(`DCF_OFS_THF);
        chk("thr_m", st, 32'h9);
        axi_rd(8'h10);
        chk("unmapped", 32'(rs), 32'(`DCF_RESP_ERR));
        axi_wr(`DCF_OFS_CTRL, 32'h1);
        chk("bresp", 32'(rs), 32'(`DCF_RESP_OK));
        repeat (3) @(posedge ref_clk_in);
        chk("warm_q", 32'(read_data_out), 32'h0);
        axi_rd(`DCF_OFS_THE);
        chk("warm_n", st, 32'h5);
        for (int i = 0; i < 17; i++)
        begin
            lf = nxt(lf);
            q.push_back(lf[17:0]);
            u_p.wr(lf[17:0], 1'h1, 1'h0);
            if (i == 2)
            begin
                repeat (6) @(posedge ref_clk_in);
                chk("ne_low", 32'(near_empty_n_out), 32'h0);
                chk("nf_high", 32'(near_full_n_out), 32'h1);
            end
        end
        repeat (6) @(posedge ref_clk_in);
        chk("full", 32'(full_space_pin_out), 32'h0);
        chk("half", 32'(half_level_n_out), 32'h0);
        chk("nf_low", 32'(near_full_n_out), 32'h0);
        chk("ne_high", 32'(near_empty_n_out), 32'h1);
        chk("no_pop", 32'(read_data_out), 32'h0);
        axi_rd(`DCF_OFS_STAT);
        chk("count", 32'(st[8+:AW+1]), 32'(1 << AW));
        for (int i = 0; i < 16; i++)
            pop_chk(q[i]);
        repeat (6) @(posedge ref_clk_in);
        chk("empty", 32'(empty_valid_pin_out), 32'h0);
        pop_chk(q[15]);
        u_p.rd(1'h0, 1'h1);
        repeat (3) u_p.rd(1'h0, 1'h0);
        pop_chk(q[0]);
        out_en_n_in <= 1'h1;
        repeat (2) @(posedge ref_clk_in);
        chk("oe_off", 32'(read_data_oe_n_out), 32'h1);
        out_en_n_in <= 1'h0;
        warm_init_n_in <= 1'h0;
        @(posedge ref_clk_in);
        warm_init_n_in <= 1'h1;
        repeat (2) @(posedge ref_clk_in);
        chk("warm_pin_q", 32'(read_data_out), 32'h0);
        axi_rd(`DCF_OFS_THF);
        chk("warm_m", st, 32'h9);
        cold(1'h1, 1'h0);
        chk("cold_q", 32'(read_data_out), 32'h0);
        chk("not_valid", 32'(empty_valid_pin_out), 32'h1);
        axi_rd(`DCF_OFS_STAT);
        chk("look_on", 32'(st[2]), 32'h1);
        lf = nxt(lf);
        u_p.wr(lf[17:0], 1'h1, 1'h0);
        repeat (4) u_p.rd(1'h0, 1'h0);
        repeat (2) @(posedge ref_clk_in);
        chk("fall", 32'(read_data_out), 32'(lf[17:0]));
        chk("valid", 32'(empty_valid_pin_out), 32'h0);
        chk("space", 32'(full_space_pin_out), 32'h0);
        test_done();
    end
endmodule
